//--- rom_byte_model.sv
// behavioural three-wire byte-wide serial ROM
// sees only cs, sk and di; wide_i gives the address width
`timescale 1ns/1ps
`default_nettype none
module rom_byte_model (
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  input  wire logic wide_i,
  output wire logic do_o
);
  logic [7:0]  mem [0:511];
  logic [11:0] sr;
  logic [8:0]  a;
  logic [2:0]  b;
  logic [1:0]  op;
  logic [1:0]  top;
  logic        d = 1'b0;
  logic        en = 1'b0;
  logic        pend = 1'b0;
  int          n = 0;
  wire [3:0]   h = wide_i ? 4'd12 : 4'd10;
  // deselected line shows the inverse, never a held value
  assign do_o = cs_i ? d : ~d;
  always @(posedge cs_i) begin
    n = 0;
    if (pend) begin d = 1'b0; #700; end // slow programming cycle
    pend = 1'b0;
    d = 1'b1;
  end
  always @(negedge cs_i) begin
    if (en && op == 2'b01 && n == h + 8) begin
      mem[a] = sr[7:0];
      pend = 1'b1;
    end
    if (en && op == 2'b11 && n == h) begin
      mem[a] = 8'hff;
      pend = 1'b1;
    end
  end
  always @(posedge sk_i) if (cs_i) begin
    if (n >= h && op == 2'b10) begin
      d = mem[a][b];
      if (b == 3'd0) a = a + 9'd1;
      b = b - 3'd1;
    end
    sr = {sr[10:0], di_i};
    n = n + 1;
    if (n == h) begin
      op = wide_i ? sr[10:9] : sr[8:7];
      a = wide_i ? sr[8:0] : {2'b00, sr[6:0]};
      top = wide_i ? sr[8:7] : sr[6:5];
      b = 3'd7;
      if (op == 2'b00) en = (top == 2'b11) ? 1'b1 : (top == 2'b00) ? 1'b0 : en;
    end
  end
endmodule // rom_byte_model
`default_nettype wire

//--- rom_link_engine.v
// three-wire serial ROM link: start bit, opcode, address, then data
// assumes the ROM data-out pin is asynchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_loader_defines.vh"

module rom_link_engine #(
  parameter HALF_CYC = `ROM_SK_HALF_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire [1:0]  mode_i,
  input  wire [11:0] hdr_i,
  input  wire [3:0]  hdr_len_i,
  input  wire [7:0]  wdata_i,
  input  wire        more_i,
  input  wire        rom_do_i,
  output reg         cs_o,
  output reg         sk_o,
  output reg         di_o,
  output reg         byte_valid_o,
  output reg  [7:0]  byte_o,
  output reg         done_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_HDR  = 3'h1;
  localparam [2:0] S_RD   = 3'h2;
  localparam [2:0] S_WR   = 3'h3;
  localparam [2:0] S_GAP  = 3'h4;
  localparam [2:0] S_POLL = 3'h5;
  localparam [7:0] HALF_LAST = HALF_CYC[7:0] - 8'h01;

  reg        do_m_reg;
  reg        do_s_reg;
  reg [7:0]  tick_cnt_reg;
  reg [2:0]  state_reg;
  reg [1:0]  mode_reg;
  reg [11:0] sr_reg;
  reg [7:0]  wd_reg;
  reg [3:0]  cnt_reg;
  reg        any_reg;
  wire       tick = (tick_cnt_reg == HALF_LAST);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      do_m_reg <= 1'b0;
      do_s_reg <= 1'b0;
    end else begin
      do_m_reg <= rom_do_i;
      do_s_reg <= do_m_reg;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      tick_cnt_reg <= 8'h00;
    else if (state_reg == S_IDLE || tick)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end

  // data changes on the falling edge, the ROM latches on the rising one
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= S_IDLE;
      mode_reg     <= `EM_CTL;
      sr_reg       <= 12'h000;
      wd_reg       <= 8'h00;
      cnt_reg      <= 4'h0;
      any_reg      <= 1'b0;
      cs_o         <= 1'b0;
      sk_o         <= 1'b0;
      di_o         <= 1'b0;
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
      done_o       <= 1'b0;
    end else begin
      byte_valid_o <= 1'b0;
      done_o       <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_i) begin
            state_reg <= S_HDR;
            mode_reg  <= mode_i;
            cs_o      <= 1'b1;
            sk_o      <= 1'b0;
            di_o      <= hdr_i[11];
            sr_reg    <= {hdr_i[10:0], 1'b0};
            wd_reg    <= wdata_i;
            cnt_reg   <= hdr_len_i - 4'h1;
            any_reg   <= 1'b0;
          end
        end
        S_HDR: begin
          if (tick && !sk_o) begin
            sk_o <= 1'b1;
          end else if (tick) begin
            sk_o <= 1'b0;
            if (cnt_reg != 4'h0) begin
              cnt_reg <= cnt_reg - 4'h1;
              di_o    <= sr_reg[11];
              sr_reg  <= {sr_reg[10:0], 1'b0};
            end else begin
              case (mode_reg)
                `EM_READ: begin
                  state_reg <= S_RD;
                  di_o      <= 1'b0;
                end
                `EM_WRITE: begin
                  state_reg <= S_WR;
                  di_o      <= wd_reg[7];
                  wd_reg    <= {wd_reg[6:0], 1'b0};
                  cnt_reg   <= 4'h7;
                end
                `EM_ERASE: begin
                  state_reg <= S_GAP;
                  cs_o      <= 1'b0;
                  di_o      <= 1'b0;
                end
                default: begin
                  state_reg <= S_IDLE;
                  cs_o      <= 1'b0;
                  di_o      <= 1'b0;
                  done_o    <= 1'b1;
                end
              endcase
            end
          end
        end
        S_RD: begin
          // the stop decision waits half a bit, so the caller sees the byte
          if (tick && !sk_o) begin
            if (any_reg && cnt_reg == 4'h0 && !more_i) begin
              state_reg <= S_IDLE;
              cs_o      <= 1'b0;
              done_o    <= 1'b1;
            end else begin
              sk_o <= 1'b1;
            end
          end else if (tick) begin
            sk_o   <= 1'b0;
            byte_o <= {byte_o[6:0], do_s_reg};
            if (cnt_reg == 4'h7) begin
              cnt_reg      <= 4'h0;
              byte_valid_o <= 1'b1;
              any_reg      <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        S_WR: begin
          if (tick && !sk_o) begin
            sk_o <= 1'b1;
          end else if (tick) begin
            sk_o <= 1'b0;
            if (cnt_reg != 4'h0) begin
              cnt_reg <= cnt_reg - 4'h1;
              di_o    <= wd_reg[7];
              wd_reg  <= {wd_reg[6:0], 1'b0};
            end else begin
              state_reg <= S_GAP;
              cs_o      <= 1'b0;
              di_o      <= 1'b0;
            end
          end
        end
        S_GAP: begin
          if (tick) begin
            state_reg <= S_POLL;
            cs_o      <= 1'b1;
          end
        end
        S_POLL: begin
          // no timeout: a ROM that never reports ready keeps the link busy
          if (tick && do_s_reg) begin
            state_reg <= S_IDLE;
            cs_o      <= 1'b0;
            done_o    <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          cs_o      <= 1'b0;
        end
      endcase
    end
  end

endmodule // rom_link_engine

`default_nettype wire

//--- serial_rom_loader.v
// boot loader: fetches the configuration image from a serial ROM at reset,
// presents the loaded fields, then passes host ROM commands to the link
// assumes straps and the ROM data pin are asynchronous to CORE_CLK_I
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_loader_defines.vh"

module serial_rom_loader #(
  parameter         EXTENDED        = 1,
  parameter [7:0]   FS_POLL_DEFAULT = 8'h01,
  parameter [7:0]   HS_POLL_DEFAULT = 8'h01,
  parameter [15:0]  LANG_DEFAULT    = 16'h0000
) (
  input  wire        CORE_CLK_I,
  input  wire        SYS_RST_I,
  input  wire        ROM_SIZE_STRAP_I,
  input  wire        REMOTE_WAKE_STRAP_I,
  input  wire        POWER_METHOD_STRAP_I,
  input  wire        ROM_DO_I,
  output wire        ROM_CS_O,
  output wire        ROM_SK_O,
  output wire        ROM_DI_O,
  input  wire        HOST_CMD_VALID_I,
  input  wire [2:0]  HOST_CMD_OP_I,
  input  wire [8:0]  HOST_CMD_ADDR_I,
  input  wire [7:0]  HOST_CMD_WDATA_I,
  output reg         HOST_CMD_BUSY_O,
  output reg         HOST_CMD_DONE_O,
  output reg  [7:0]  HOST_RDATA_O,
  output reg         USB_HOLD_O,
  output reg         LOAD_DONE_O,
  output reg         ROM_VALID_O,
  output reg  [15:0] STATION_ADDR_HIGH_O,
  output reg  [31:0] STATION_ADDR_LOW_O,
  output reg  [7:0]  FS_POLL_O,
  output reg  [7:0]  HS_POLL_O,
  output reg  [15:0] LANG_ID_O,
  output reg         LANG_ID_PRESENT_O,
  output reg         REMOTE_WAKE_O,
  output reg         SELF_POWERED_O,
  output reg         ATTR_FROM_DESC_O,
  output reg  [1:0]  LINE_DRIVE_BOOST_O,
  output reg         LED_FUNCTION_SELECT_O,
  output reg  [71:0] DESC_LEN_O,
  output reg  [80:0] DESC_ADDR_O,
  output reg  [8:0]  DESC_PRESENT_O,
  output reg  [7:0]  DEV_DESC_TYPE_O,
  output reg  [7:0]  DEV_DESC_SIZE_O,
  output reg  [7:0]  CFG_DESC_TYPE_O,
  output reg  [10:0] PIN_WAKE_ENABLES_O,
  output reg  [7:0]  PIN_POWER_EVENT_O
);

  localparam [2:0] L_SETTLE = 3'h0;
  localparam [2:0] L_START  = 3'h1;
  localparam [2:0] L_LOAD   = 3'h2;
  localparam [2:0] L_APPLY  = 3'h3;
  localparam [2:0] L_READY  = 3'h4;
  localparam [2:0] L_HOST   = 3'h5;
  localparam [5:0] LAST_IDX =
    (EXTENDED != 0) ? `ROM_A_LAST_EXT : `ROM_A_LAST_BASE;
  localparam [5:0] IMG_BYTES = LAST_IDX + 6'h01;

  // start bit, opcode, then the address at the strap-selected width
  function [11:0] mk_hdr;
    input [1:0] op;
    input [8:0] addr;
    input       wide;
    begin
      if (wide)
        mk_hdr = {1'b1, op, addr};
      else
        mk_hdr = {1'b1, op, addr[6:0], 2'b00};
    end
  endfunction

  // control commands carry their subcode in the top two address bits
  function [8:0] ctl_addr;
    input [1:0] sub;
    input       wide;
    begin
      if (wide)
        ctl_addr = {sub, 7'h00};
      else
        ctl_addr = {2'b00, sub, 5'h00};
    end
  endfunction

  reg [2:0]  strap_m_reg;
  reg [2:0]  strap_s_reg;
  reg        wide_reg;
  reg [1:0]  settle_reg;
  reg [2:0]  state_reg;
  reg [5:0]  byte_idx_reg;
  reg [7:0]  img_reg [0:32];
  reg        eng_start_reg;
  reg [1:0]  eng_mode_reg;
  reg [11:0] eng_hdr_reg;
  reg [7:0]  eng_wdata_reg;
  wire       eng_byte_valid;
  wire [7:0] eng_byte;
  wire       eng_done;
  wire       marker_ok = (img_reg[`ROM_A_MARKER] == `ROM_MARKER);
  wire       load_ok   = marker_ok && (byte_idx_reg == IMG_BYTES);
  // keep reading while bytes remain and the marker matched
  wire       more_w    = (state_reg == L_LOAD) && marker_ok &&
                         (byte_idx_reg < IMG_BYTES);
  wire [3:0] hdr_len   = wide_reg ? `ROM_HDR_LARGE : `ROM_HDR_SMALL;
  integer    k;

  rom_link_engine u_link (
    .clk_i        (CORE_CLK_I),
    .rst_i        (SYS_RST_I),
    .start_i      (eng_start_reg),
    .mode_i       (eng_mode_reg),
    .hdr_i        (eng_hdr_reg),
    .hdr_len_i    (hdr_len),
    .wdata_i      (eng_wdata_reg),
    .more_i       (more_w),
    .rom_do_i     (ROM_DO_I),
    .cs_o         (ROM_CS_O),
    .sk_o         (ROM_SK_O),
    .di_o         (ROM_DI_O),
    .byte_valid_o (eng_byte_valid),
    .byte_o       (eng_byte),
    .done_o       (eng_done)
  );

  always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      strap_m_reg <= 3'h0;
      strap_s_reg <= 3'h0;
    end else begin
      strap_m_reg <= {ROM_SIZE_STRAP_I, REMOTE_WAKE_STRAP_I,
                      POWER_METHOD_STRAP_I};
      strap_s_reg <= strap_m_reg;
    end
  end

  // image storage: one byte per location, written as the read streams in
  always @(posedge CORE_CLK_I) begin
    if (state_reg == L_LOAD && eng_byte_valid && byte_idx_reg <= LAST_IDX)
      img_reg[byte_idx_reg] <= eng_byte;
  end

  always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg             <= L_SETTLE;
      settle_reg            <= 2'h0;
      wide_reg              <= 1'b0;
      byte_idx_reg          <= 6'h00;
      eng_start_reg         <= 1'b0;
      eng_mode_reg          <= `EM_READ;
      eng_hdr_reg           <= 12'h000;
      eng_wdata_reg         <= 8'h00;
      HOST_CMD_BUSY_O       <= 1'b1;
      HOST_CMD_DONE_O       <= 1'b0;
      HOST_RDATA_O          <= 8'h00;
      USB_HOLD_O            <= 1'b1;
      LOAD_DONE_O           <= 1'b0;
      ROM_VALID_O           <= 1'b0;
      STATION_ADDR_HIGH_O   <= 16'h0000;
      STATION_ADDR_LOW_O    <= 32'h00000000;
      FS_POLL_O             <= FS_POLL_DEFAULT;
      HS_POLL_O             <= HS_POLL_DEFAULT;
      LANG_ID_O             <= LANG_DEFAULT;
      LANG_ID_PRESENT_O     <= 1'b0;
      REMOTE_WAKE_O         <= 1'b0;
      SELF_POWERED_O        <= 1'b0;
      ATTR_FROM_DESC_O      <= 1'b0;
      LINE_DRIVE_BOOST_O    <= 2'h0;
      LED_FUNCTION_SELECT_O <= 1'b0;
      DESC_LEN_O            <= 72'h0;
      DESC_ADDR_O           <= 81'h0;
      DESC_PRESENT_O        <= 9'h000;
      DEV_DESC_TYPE_O       <= `DEV_DESC_TYPE;
      DEV_DESC_SIZE_O       <= `DEV_DESC_SIZE;
      CFG_DESC_TYPE_O       <= `CFG_DESC_TYPE;
      PIN_WAKE_ENABLES_O    <= 11'h000;
      PIN_POWER_EVENT_O     <= 8'h00;
    end else begin
      eng_start_reg   <= 1'b0;
      HOST_CMD_DONE_O <= 1'b0;
      case (state_reg)
        L_SETTLE: begin
          // let the strap synchronisers fill before sampling
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == 2'h3) begin
            wide_reg  <= strap_s_reg[2];
            state_reg <= L_START;
          end
        end
        L_START: begin
          eng_hdr_reg   <= mk_hdr(`OP_READ, 9'h000, wide_reg);
          eng_mode_reg  <= `EM_READ;
          eng_start_reg <= 1'b1;
          byte_idx_reg  <= 6'h00;
          state_reg     <= L_LOAD;
        end
        L_LOAD: begin
          if (eng_byte_valid && byte_idx_reg <= LAST_IDX)
            byte_idx_reg <= byte_idx_reg + 6'h01;
          if (eng_done)
            state_reg <= L_APPLY;
        end
        L_APPLY: begin
          ROM_VALID_O <= load_ok;
          if (load_ok) begin
            STATION_ADDR_LOW_O  <= {img_reg[4], img_reg[3],
                                    img_reg[2], img_reg[1]};
            STATION_ADDR_HIGH_O <= {img_reg[6], img_reg[5]};
            FS_POLL_O           <= img_reg[`ROM_A_FS_POLL];
            HS_POLL_O           <= img_reg[`ROM_A_HS_POLL];
            LANG_ID_O           <= {img_reg[`ROM_A_LANG + 1],
                                    img_reg[`ROM_A_LANG]};
            // flags replace the straps outright
            REMOTE_WAKE_O       <= img_reg[`ROM_A_FLAGS][`FLG_WAKE];
            SELF_POWERED_O      <= img_reg[`ROM_A_FLAGS][`FLG_POWER];
            ATTR_FROM_DESC_O    <= (img_reg[`ROM_A_HS_CFG_LEN] != 8'h00) ||
                                   (img_reg[`ROM_A_FS_CFG_LEN] != 8'h00);
          end else begin
            REMOTE_WAKE_O       <= strap_s_reg[1];
            SELF_POWERED_O      <= strap_s_reg[0];
          end
          if (load_ok && EXTENDED != 0) begin
            LINE_DRIVE_BOOST_O    <=
              img_reg[`ROM_A_FLAGS][`FLG_BOOST +: 2];
            LED_FUNCTION_SELECT_O <= img_reg[`ROM_A_FLAGS][`FLG_LED];
            PIN_WAKE_ENABLES_O    <= {img_reg[`ROM_A_WAKE_HI][2:0],
                                      img_reg[`ROM_A_WAKE_LO]};
            // an event byte with its enable clear is dropped whole
            PIN_POWER_EVENT_O     <= img_reg[`ROM_A_PME][`PME_ENABLE] ?
                                     img_reg[`ROM_A_PME] : 8'h00;
          end
          LANG_ID_PRESENT_O <= 1'b1;
          if (load_ok) begin
            LANG_ID_PRESENT_O <= 1'b0;
            for (k = 0; k < `ROM_STRING_COUNT; k = k + 1) begin
              if (img_reg[`ROM_A_DESC + 2 * k] != 8'h00)
                LANG_ID_PRESENT_O <= 1'b1;
            end
          end
          for (k = 0; k < `ROM_DESC_COUNT; k = k + 1) begin
            DESC_LEN_O[k * 8 +: 8] <= load_ok ?
              img_reg[`ROM_A_DESC + 2 * k] : 8'h00;
            DESC_ADDR_O[k * 9 +: 9] <= load_ok ?
              {img_reg[`ROM_A_DESC + 2 * k + 1], 1'b0} : 9'h000;
            DESC_PRESENT_O[k] <= load_ok &&
              (img_reg[`ROM_A_DESC + 2 * k] != 8'h00);
          end
          // type and size never come from the image
          DEV_DESC_TYPE_O <= `DEV_DESC_TYPE;
          DEV_DESC_SIZE_O <= `DEV_DESC_SIZE;
          CFG_DESC_TYPE_O <= `CFG_DESC_TYPE;
          LOAD_DONE_O     <= 1'b1;
          USB_HOLD_O      <= 1'b0;
          HOST_CMD_BUSY_O <= 1'b0;
          state_reg       <= L_READY;
        end
        L_READY: begin
          if (HOST_CMD_VALID_I) begin
            HOST_CMD_BUSY_O <= 1'b1;
            eng_start_reg   <= 1'b1;
            eng_wdata_reg   <= HOST_CMD_WDATA_I;
            state_reg       <= L_HOST;
            case (HOST_CMD_OP_I)
              `HOP_READ: begin
                eng_mode_reg <= `EM_READ;
                eng_hdr_reg  <= mk_hdr(`OP_READ, HOST_CMD_ADDR_I, wide_reg);
              end
              `HOP_WRITE: begin
                eng_mode_reg <= `EM_WRITE;
                eng_hdr_reg  <= mk_hdr(`OP_WRITE, HOST_CMD_ADDR_I, wide_reg);
              end
              `HOP_ERASE: begin
                eng_mode_reg <= `EM_ERASE;
                eng_hdr_reg  <= mk_hdr(`OP_ERASE, HOST_CMD_ADDR_I, wide_reg);
              end
              `HOP_EWEN: begin
                eng_mode_reg <= `EM_CTL;
                eng_hdr_reg  <= mk_hdr(`OP_CTL,
                                  ctl_addr(`SUB_EWEN, wide_reg), wide_reg);
              end
              default: begin
                // unknown codes fall back to write-disable, the safe one
                eng_mode_reg <= `EM_CTL;
                eng_hdr_reg  <= mk_hdr(`OP_CTL,
                                  ctl_addr(`SUB_EWDS, wide_reg), wide_reg);
              end
            endcase
          end
        end
        L_HOST: begin
          if (eng_byte_valid)
            HOST_RDATA_O <= eng_byte;
          if (eng_done) begin
            HOST_CMD_DONE_O <= 1'b1;
            HOST_CMD_BUSY_O <= 1'b0;
            state_reg       <= L_READY;
          end
        end
        default: begin
          state_reg <= L_SETTLE;
        end
      endcase
    end
  end

endmodule // serial_rom_loader

`default_nettype wire

//--- serial_rom_loader_defines.vh
// constants for the serial ROM boot loader: image layout, opcodes, timing
// assumes a three-wire byte-wide serial ROM and a 200 MHz core clock
//
// Summary of operation
// - size strap 0 selects seven address bits, strap 1 selects nine
// - bytes 01h-06h, least significant first, form the default station address
// - image counts only when byte 00h holds A5h, else nothing is loaded
// - every system reset starts the load by itself
// - host USB transactions are refused until the load has finished
// - after loading the host may read, write and erase the ROM
// - descriptor offsets count 16-bit words, so byte address is offset times two
// - zero descriptor length means absent; built-in default is used
// - all string lengths zero means no language identifier is offered
// - full-speed poll interval at 07h, high-speed at 08h
// - language identifier low byte at 0Ah, high byte at 0Bh
// - 0Ch-1Dh hold length then word offset for nine descriptors
// - flag bit 2 gives remote wake, bit 0 gives self powered
// - flag bits 5:4 give line drive boost, bit 1 LED select, in the extended variant only
// - flags beat wake and power straps; a configuration descriptor beats both
// - device type forced 01h, size 12h, configuration type 02h
// - extended variant loads wake enables from 1Eh-1Fh, event flags from 20h
// - event flag bit 7 clear means the whole event byte is ignored
`ifndef SERIAL_ROM_LOADER_DEFINES_VH
`define SERIAL_ROM_LOADER_DEFINES_VH

`define ROM_MARKER       8'ha5
`define ROM_A_MARKER     6'h00
`define ROM_A_MAC        6'h01
`define ROM_A_FS_POLL    6'h07
`define ROM_A_HS_POLL    6'h08
`define ROM_A_FLAGS      6'h09
`define ROM_A_LANG       6'h0a
`define ROM_A_DESC       6'h0c
`define ROM_A_HS_CFG_LEN 6'h18
`define ROM_A_FS_CFG_LEN 6'h1c
`define ROM_A_LAST_BASE  6'h1d
`define ROM_A_WAKE_LO    6'h1e
`define ROM_A_WAKE_HI    6'h1f
`define ROM_A_PME        6'h20
`define ROM_A_LAST_EXT   6'h20
`define ROM_DESC_COUNT   9
`define ROM_STRING_COUNT 5

`define FLG_POWER        0
`define FLG_LED          1
`define FLG_WAKE         2
`define FLG_BOOST        4
`define PME_ENABLE       7

`define ROM_ABITS_SMALL  7
`define ROM_ABITS_LARGE  9
`define ROM_HDR_SMALL    4'ha
`define ROM_HDR_LARGE    4'hc

`define OP_READ          2'b10
`define OP_WRITE         2'b01
`define OP_ERASE         2'b11
`define OP_CTL           2'b00
`define SUB_EWEN         2'b11
`define SUB_EWDS         2'b00

`define HOP_READ         3'h0
`define HOP_WRITE        3'h1
`define HOP_ERASE        3'h2
`define HOP_EWEN         3'h3
`define HOP_EWDS         3'h4

`define EM_READ          2'h0
`define EM_WRITE         2'h1
`define EM_ERASE         2'h2
`define EM_CTL           2'h3

`define DEV_DESC_TYPE    8'h01
`define DEV_DESC_SIZE    8'h12
`define CFG_DESC_TYPE    8'h02

`define CORE_CLK_MHZ     200
`define ROM_SK_HALF_NS   500
`define ROM_SK_HALF_CYC  ((`ROM_SK_HALF_NS*`CORE_CLK_MHZ+999)/1000)

`endif

//--- serial_rom_loader_monitor.sv
// assertions on the serial ROM boot loader ports
// bound to serial_rom_loader from the bench top file
`timescale 1ns/1ps
`default_nettype none
module serial_rom_loader_monitor (
  input wire logic       CORE_CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       HOST_CMD_VALID_I,
  input wire logic       HOST_CMD_BUSY_O,
  input wire logic       HOST_CMD_DONE_O,
  input wire logic       USB_HOLD_O,
  input wire logic       LOAD_DONE_O,
  input wire logic       ROM_VALID_O,
  input wire logic       ROM_CS_O,
  input wire logic       ROM_SK_O,
  input wire logic       ROM_DI_O,
  input wire logic       ATTR_FROM_DESC_O,
  input wire logic [8:0] DESC_PRESENT_O,
  input wire logic [7:0] PIN_POWER_EVENT_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_take;
    HOST_CMD_VALID_I && !HOST_CMD_BUSY_O && LOAD_DONE_O;
  endsequence
  sequence s_finish;
    !HOST_CMD_BUSY_O && $past(HOST_CMD_BUSY_O) ##1 !HOST_CMD_DONE_O;
  endsequence
  a_hold_load: assert property (USB_HOLD_O != LOAD_DONE_O)
    else $error("usb hold disagrees with load done");
  a_done_stays: assert property (LOAD_DONE_O |=> LOAD_DONE_O)
    else $error("load done dropped");
  a_busy_load: assert property (!LOAD_DONE_O |-> HOST_CMD_BUSY_O)
    else $error("host command open before load");
  a_take_busy: assert property (s_take |=> HOST_CMD_BUSY_O)
    else $error("taken command not busy");
  a_done_pulse: assert property ($rose(HOST_CMD_DONE_O) |-> s_finish)
    else $error("done pulse malformed");
  a_cs_start: assert property ($rose(ROM_CS_O) |-> !ROM_SK_O &&
    (ROM_DI_O || HOST_CMD_BUSY_O && LOAD_DONE_O))
    else $error("frame start bit wrong");
  a_sk_phase: assert property ($rose(ROM_SK_O) |->
    (ROM_SK_O && $stable(ROM_DI_O)) [*8]) else $error("sk high phase short");
  a_attr_desc: assert property (ATTR_FROM_DESC_O ==
    (DESC_PRESENT_O[6] || DESC_PRESENT_O[8])) else $error("attr override");
  a_pme_gate: assert property (!PIN_POWER_EVENT_O[7] |->
    PIN_POWER_EVENT_O == 8'h00) else $error("event byte not gated");
  a_valid_done: assert property (ROM_VALID_O |-> LOAD_DONE_O)
    else $error("valid before load done");
endmodule // serial_rom_loader_monitor
`default_nettype wire

//--- tb_serial_rom_loader.sv
// self-checking bench for the serial ROM boot loader
// a byte ROM model answers the link; expectations come from img
`timescale 1ns/1ps
`default_nettype none
module tb_serial_rom_loader;
  logic CORE_CLK_I, SYS_RST_I, ROM_SIZE_STRAP_I, REMOTE_WAKE_STRAP_I;
  logic POWER_METHOD_STRAP_I, HOST_CMD_VALID_I, ROM_DO_I, ROM_CS_O;
  logic ROM_SK_O, ROM_DI_O, HOST_CMD_BUSY_O, HOST_CMD_DONE_O, USB_HOLD_O;
  logic LOAD_DONE_O, ROM_VALID_O, LANG_ID_PRESENT_O, REMOTE_WAKE_O;
  logic SELF_POWERED_O, ATTR_FROM_DESC_O, LED_FUNCTION_SELECT_O;
  logic [2:0] HOST_CMD_OP_I;
  logic [8:0] HOST_CMD_ADDR_I, DESC_PRESENT_O;
  logic [7:0] HOST_CMD_WDATA_I, HOST_RDATA_O, FS_POLL_O, HS_POLL_O;
  logic [7:0] DEV_DESC_TYPE_O, DEV_DESC_SIZE_O, CFG_DESC_TYPE_O;
  logic [7:0] PIN_POWER_EVENT_O;
  logic [15:0] STATION_ADDR_HIGH_O, LANG_ID_O;
  logic [31:0] STATION_ADDR_LOW_O;
  logic [1:0] LINE_DRIVE_BOOST_O;
  logic [71:0] DESC_LEN_O;
  logic [80:0] DESC_ADDR_O;
  logic [10:0] PIN_WAKE_ENABLES_O;
  logic [7:0] img [0:511];
  logic [31:0] lf = 32'ha5a17133;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  serial_rom_loader dut_u (.*);
  rom_byte_model rom_u (.cs_i(ROM_CS_O), .sk_i(ROM_SK_O), .di_i(ROM_DI_O),
    .wide_i(ROM_SIZE_STRAP_I), .do_o(ROM_DO_I));
  initial CORE_CLK_I = 1'b0;
  always #2.5 CORE_CLK_I = ~CORE_CLK_I;
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  task automatic tick();
    @(posedge CORE_CLK_I);
    #1;
  endtask
  task automatic chk(input logic [80:0] got, input logic [80:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 99000) begin
      failures++;
      stop_test();
    end
  end
  task automatic boot(input logic wide);
    SYS_RST_I = 1'b1;
    ROM_SIZE_STRAP_I = wide;
    for (int i = 0; i < 512; i++) rom_u.mem[i] = img[i];
    repeat (5) tick();
    SYS_RST_I = 1'b0;
    repeat (20) tick();
    chk(USB_HOLD_O, 1'b1);
    for (int i = 0; i < 70000 && LOAD_DONE_O !== 1'b1; i++) tick();
    chk(USB_HOLD_O, 1'b0);
  endtask
  task automatic host(input logic [2:0] op, input logic [8:0] a,
                      input logic [7:0] d);
    HOST_CMD_OP_I = op;
    HOST_CMD_ADDR_I = a;
    HOST_CMD_WDATA_I = d;
    HOST_CMD_VALID_I = 1'b1;
    tick();
    HOST_CMD_VALID_I = 1'b0;
    for (int i = 0; i < 9000 && HOST_CMD_DONE_O !== 1'b1; i++) tick();
    chk(HOST_CMD_DONE_O, 1'b1);
    tick();
  endtask
  initial begin
    logic [8:0] a;
    logic [7:0] d;
    {SYS_RST_I, HOST_CMD_VALID_I, HOST_CMD_OP_I, HOST_CMD_ADDR_I} = '0;
    {HOST_CMD_WDATA_I, ROM_SIZE_STRAP_I, REMOTE_WAKE_STRAP_I} = '0;
    POWER_METHOD_STRAP_I = 1'b1;
    for (int i = 0; i < 512; i++) img[i] = rnd();
    img[0] = 8'ha5;
    for (int k = 0; k < 9; k++) img[12+2*k] = k < 5 ? 8'h00
      : img[12+2*k][0] ? 8'h12 : 8'h00;
    for (int k = 5; k < 9; k++) img[13+2*k] = k[0] ? 8'h40 : 8'h50;
    {img[130], img[131], img[135], img[145]} = 32'h00024001;
    {img[142], img[143], img[144], img[166], img[177]} = '0;
    boot(1'b0);
    chk(ROM_VALID_O, 1'b1);
    chk({STATION_ADDR_HIGH_O, STATION_ADDR_LOW_O},
      {img[6], img[5], img[4], img[3], img[2], img[1]});
    chk({FS_POLL_O, HS_POLL_O, LANG_ID_O}, {img[7], img[8], img[11], img[10]});
    chk({LANG_ID_PRESENT_O, REMOTE_WAKE_O, SELF_POWERED_O},
      {1'b0, img[9][2], img[9][0]});
    chk({LINE_DRIVE_BOOST_O, LED_FUNCTION_SELECT_O}, {img[9][5:4], img[9][1]});
    for (int k = 0; k < 9; k++) begin
      chk(DESC_LEN_O[8*k+:8], img[12+2*k]);
      chk(DESC_ADDR_O[9*k+:9], {img[13+2*k], 1'b0});
      chk(DESC_PRESENT_O[k], img[12+2*k] != 8'h00);
    end
    chk({DEV_DESC_TYPE_O, DEV_DESC_SIZE_O, CFG_DESC_TYPE_O}, 24'h011202);
    chk({PIN_WAKE_ENABLES_O, PIN_POWER_EVENT_O}, {img[31][2:0], img[30],
      img[32][7] ? img[32] : 8'h00});
    a = {1'b0, rnd() & 8'h7f};
    d = rnd();
    host(3'h3, 9'h000, 8'h00);
    host(3'h1, a, d);
    host(3'h2, a ^ 9'h001, 8'h00);
    host(3'h0, a, 8'h00);
    chk(HOST_RDATA_O, d);
    host(3'h0, a ^ 9'h001, 8'h00);
    chk(HOST_RDATA_O, 8'hff);
    host(3'h4, 9'h000, 8'h00);
    img[0] = 8'h5a;
    img[9'h1a3] = ~img[9'h023];
    REMOTE_WAKE_STRAP_I = 1'b1;
    POWER_METHOD_STRAP_I = 1'b0;
    boot(1'b1);
    chk({ROM_VALID_O, LANG_ID_PRESENT_O, REMOTE_WAKE_O, SELF_POWERED_O},
      4'b0110);
    chk({STATION_ADDR_LOW_O, FS_POLL_O, DESC_PRESENT_O}, 49'h200);
    host(3'h0, 9'h1a3, 8'h00);
    chk(HOST_RDATA_O, img[9'h1a3]);
    stop_test();
  end
endmodule // tb_serial_rom_loader
bind serial_rom_loader serial_rom_loader_monitor mon_u (.*);
`default_nettype wire
